/* File: core/tape_mark_track_flag_control.sv */
`default_nettype none
module tape_mark_track_flag_control
   import tape_ctl_pkg::*;
#(
   parameter int LINE_HALF = LINE_HALF_CYC
) (
   // clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_sys_rst,
   // host register port
   input  wire host_req_t         i_host,
   output var  logic [WORD_W-1:0] o_rd_data,
   // tape transport
   input  wire tape_in_t          i_tape,
   input  wire logic              i_permit_sw,
   output var  tape_out_t         o_tape,
   output var  logic              o_warn_lamp,
   output var  logic              o_break_req
);

   if (LINE_HALF < 1 || LINE_HALF > 65535) begin : g_bad_line_half
      $error("LINE_HALF out of range");
   end

   localparam logic [2:0]  CNT_LAST  = 3'(LINES_PER_WORD - 1);
   localparam logic [15:0] HALF_LAST = 16'(LINE_HALF - 1);

   // mark or its complement obverse
   function automatic logic mark_is(input logic [5:0] code, input logic [5:0] k);
      logic [5:0] obv;
      obv = ~{k[0], k[1], k[2], k[3], k[4], k[5]};
      return (code == k) || (code == obv);
   endfunction : mark_is

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   tape_in_t tin_s1_r;
   tape_in_t tin_s2_r;
   logic     permit_s1_r;
   logic     permit_s2_r;
   logic     tim_d_r;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         tin_s1_r    <= '0;
         tin_s2_r    <= '0;
         permit_s1_r <= 1'b0;
         permit_s2_r <= 1'b0;
         tim_d_r     <= 1'b0;
      end else begin
         tin_s1_r    <= i_tape;
         tin_s2_r    <= tin_s1_r;
         permit_s1_r <= i_permit_sw;
         permit_s2_r <= permit_s1_r;
         tim_d_r     <= tin_s2_r.tim;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   mode_t             mode_r;
   logic              go_r;
   logic              rev_r;
   logic              brk_r;
   logic [WORD_W-1:0] buf_r;
   logic              flag_data_r;
   logic              flag_end_r;
   logic              flag_err_r;
   logic [WIN_W-1:0]  win_r;
   logic [2:0]        cnt_r;
   logic              synced_r;
   logic [1:0]        tail_r;
   logic [WORD_W-1:0] asm_r;
   logic [WORD_W-1:0] wsr_r;
   logic              wr_en_r;
   phase_t            phase_r;
   logic [15:0]       div_r;
   logic              tim_gen_r;

   ////////////////////////////////////////////////////////////////////////////
   // host decode
   wire wr_ctrl = i_host.wr && (i_host.addr == ADDR_CTRL);
   wire wr_stat = i_host.wr && (i_host.addr == ADDR_STAT);
   wire wr_buf  = i_host.wr && (i_host.addr == ADDR_BUF);
   wire rd_buf  = i_host.rd && (i_host.addr == ADDR_BUF);

   wire is_search = (mode_r == MODE_SEARCH);
   wire is_read   = (mode_r == MODE_READ);
   wire is_write  = (mode_r == MODE_WRITE);
   // R2: mode and switch together
   wire wtm_on    = (mode_r == MODE_WTM) && permit_s2_r;

   ////////////////////////////////////////////////////////////////////////////
   // line strobe: tape timing track, or own clock while writing it
   wire div_done   = (div_r == HALF_LAST);
   wire gen_strobe = wtm_on && div_done && !tim_gen_r;
   wire tape_edge  = tin_s2_r.tim && !tim_d_r;
   wire strobe     = wtm_on ? gen_strobe : tape_edge;

   // R24: reverse motion fills from the top, complemented
   wire [TRACKS-1:0] trk     = tin_s2_r.data;
   wire [TRACKS-1:0] trk_rev = ~{trk[0], trk[1], trk[2]};
   wire [WORD_W-1:0] asm_nxt = rev_r ? {trk_rev, asm_r[WORD_W-1:TRACKS]}
                                     : {asm_r[WORD_W-TRACKS-1:0], trk};

   // R8: window shifts once per strobe
   wire [WIN_W-1:0]  win_nxt = {win_r[WIN_W-2:0], tin_s2_r.mark};
   wire [5:0]        code    = win_nxt[MARK_W-1:0];
   wire              word_end = strobe && (cnt_r == CNT_LAST);

   // R23: obverse-insensitive decode
   wire hit_block = mark_is(code, MK_BLOCK);
   wire hit_rchk  = mark_is(code, MK_RCHK);
   wire hit_data  = mark_is(code, MK_DATA);
   wire hit_pre   = mark_is(code, MK_PRE);
   wire hit_final = mark_is(code, MK_FINAL);
   wire hit_end   = mark_is(code, MK_END);
   wire any_hit   = hit_block | hit_rchk | hit_data | hit_pre | hit_final | hit_end;

   // R9: preceding tail must match
   wire tail_ok  = !synced_r || (win_nxt[WIN_W-1:MARK_W] == tail_r);
   // R10: decoding runs in every mode except mark writing
   wire check    = strobe && !wtm_on && (synced_r ? (cnt_r == CNT_LAST) : 1'b1);
   wire mark_ok  = check && any_hit && tail_ok;
   // R21: missing mark after six shifts
   wire mark_bad = check && synced_r && !(any_hit && tail_ok);
   // R25: end zone in normal modes
   wire end_stop = mark_ok && hit_end && go_r;

   ////////////////////////////////////////////////////////////////////////////
   // flag sources
   // R11: search flags block marks only
   wire srch_set = is_search && mark_ok && hit_block;
   // R20: read starts at the reverse check sum
   wire read_set = is_read && mark_ok && (hit_rchk || hit_data);
   wire read_end = is_read && mark_ok && hit_final;
   // R13: block mark writes reverse sum and asks first word
   wire wr_start = is_write && mark_ok && hit_block;
   // R14: each data slot asks the word two ahead
   wire wr_word  = is_write && mark_ok && (hit_rchk || hit_data)
                   && ((phase_r == PH_RCHK) || (phase_r == PH_DATA));
   // R16: prefinal asks for check sum
   wire wr_pre   = is_write && mark_ok && hit_pre && (phase_r == PH_DATA);
   wire wr_csum  = is_write && mark_ok && hit_final && (phase_r == PH_CSUM);
   // R18: writers drop once the check sum has passed
   wire wr_off   = word_end && (phase_r == PH_OFF);
   wire wtm_word = wtm_on && word_end;

   // R5: move mode raises no transfer flags
   wire set_data = srch_set | read_set | wr_start | wr_word | wtm_word;
   wire set_end  = read_end | wr_pre;
   // R6: unserved flag means a lost word
   wire lost     = (set_data | set_end) && (flag_data_r || flag_end_r);
   wire set_err  = mark_bad | end_stop | lost;
   wire hw_load  = srch_set | read_set | read_end;

   // R26: transfer clears data and end, write-one clears any; a new request wins
   wire xfer     = rd_buf | wr_buf;
   wire clr_data = xfer || (wr_stat && i_host.wdata[STAT_DATA_BIT]);
   wire clr_end  = xfer || (wr_stat && i_host.wdata[STAT_END_BIT]);
   wire clr_err  = wr_stat && i_host.wdata[STAT_ERR_BIT];

   wire [WORD_W-1:0] load_val = srch_set ? {asm_nxt[WORD_W-1:6], 6'h00} : asm_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // control and flags
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         mode_r <= MODE_MOVE;
         rev_r  <= 1'b0;
         brk_r  <= 1'b0;
      end else if (wr_ctrl) begin
         mode_r <= mode_t'(i_host.wdata[CTRL_MODE_LSB +: MODE_W]);
         rev_r  <= i_host.wdata[CTRL_REV_BIT];
         brk_r  <= i_host.wdata[CTRL_BRK_BIT];
      end
   end

   // R25: end mark stop beats a host start
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || end_stop) begin
         go_r <= 1'b0;
      end else if (wr_ctrl) begin
         go_r <= i_host.wdata[CTRL_GO_BIT];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         flag_data_r <= 1'b0;
         flag_end_r  <= 1'b0;
         flag_err_r  <= 1'b0;
      end else begin
         flag_data_r <= set_data | (flag_data_r & ~clr_data);
         flag_end_r  <= set_end | (flag_end_r & ~clr_end);
         flag_err_r  <= set_err | (flag_err_r & ~clr_err);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         buf_r <= '0;
      end else if (hw_load) begin
         buf_r <= load_val;
      end else if (wr_buf) begin
         buf_r <= i_host.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // window, word framing, read assembly
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         win_r <= '0;
         asm_r <= '0;
         cnt_r <= '0;
      end else if (strobe) begin
         win_r <= win_nxt;
         asm_r <= asm_nxt;
         cnt_r <= (mark_ok || word_end) ? 3'h0 : cnt_r + 3'h1;
      end
   end

   // lost framing returns to hunting every line
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || wtm_on || mark_bad) begin
         synced_r <= 1'b0;
         tail_r   <= '0;
      end else if (mark_ok) begin
         synced_r <= 1'b1;
         tail_r   <= code[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write sequencing
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !is_write) begin
         phase_r <= PH_IDLE;
         wr_en_r <= 1'b0;
      end else if (wr_start) begin
         phase_r <= PH_RCHK;
         wr_en_r <= 1'b1;
      end else if (wr_word) begin
         phase_r <= PH_DATA;
      end else if (wr_pre) begin
         phase_r <= PH_CSUM;
      end else if (wr_csum) begin
         phase_r <= PH_OFF;
      end else if (wr_off) begin
         // R19: idle until next block mark restarts
         phase_r <= PH_IDLE;
         wr_en_r <= 1'b0;
      end
   end

   // R1: a word leaves as six three-bit lines
   wire [TRACKS-1:0] line_fwd = wsr_r[WORD_W-1:WORD_W-TRACKS];
   wire [TRACKS-1:0] line_rev = ~{wsr_r[0], wsr_r[1], wsr_r[2]};
   wire [TRACKS-1:0] line_out = rev_r ? line_rev : line_fwd;
   wire [WORD_W-1:0] wsr_sh   = rev_r ? {{TRACKS{1'b0}}, wsr_r[WORD_W-1:TRACKS]}
                                      : {wsr_r[WORD_W-TRACKS-1:0], {TRACKS{1'b0}}};

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         wsr_r <= '0;
      end else if (wr_start) begin
         wsr_r <= RCHK_VALUE;
      end else if (wr_word || wr_pre || wr_csum || wtm_word) begin
         wsr_r <= buf_r;
      end else if (strobe) begin
         wsr_r <= wsr_sh;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timing track generator for mark writing
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !wtm_on) begin
         div_r     <= '0;
         tim_gen_r <= 1'b0;
      end else if (div_done) begin
         div_r     <= '0;
         tim_gen_r <= ~tim_gen_r;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   wire [WORD_W-1:0] ctrl_rd = WORD_W'({brk_r, rev_r, go_r, mode_r});
   wire [WORD_W-1:0] stat_rd = WORD_W'({synced_r, permit_s2_r, flag_err_r,
                                        flag_end_r, flag_data_r});
   wire [WORD_W-1:0] rd_sel  = (i_host.addr == ADDR_CTRL) ? ctrl_rd :
                               (i_host.addr == ADDR_STAT) ? stat_rd :
                               (i_host.addr == ADDR_BUF)  ? buf_r   : '0;

   tape_out_t tape_nxt;
   always_comb begin
      tape_nxt         = '0;
      tape_nxt.run     = go_r;
      tape_nxt.rev     = rev_r;
      tape_nxt.data    = line_out;
      tape_nxt.data_en = (wr_en_r && is_write) || wtm_on;
      // R3: channel one feeds the mark track
      tape_nxt.mark    = wtm_on && line_out[0];
      tape_nxt.tim     = wtm_on && tim_gen_r;
      // R2: tracks undriven otherwise
      tape_nxt.tm_en   = wtm_on;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_rd_data   <= '0;
         o_tape      <= '0;
         o_warn_lamp <= 1'b0;
         o_break_req <= 1'b0;
      end else begin
         o_rd_data   <= i_host.rd ? rd_sel : '0;
         o_tape      <= tape_nxt;
         // R4: lamp follows permit switch
         o_warn_lamp <= permit_s2_r;
         // R7: any flag breaks when enabled
         o_break_req <= brk_r && (flag_data_r || flag_end_r || flag_err_r);
      end
   end

endmodule : tape_mark_track_flag_control
`default_nettype wire

/* File: core/tape_ctl_pkg.sv */
// Function
// R1: word is six lines of three bits
// R2: timing/mark writes need mode and permit switch
// R3: channel one copied to mark track
// R4: permit switch lights warning lamp
// R5: search, read, write, move modes
// R6: host serves flag in time, else error
// R7: any flag requests break when enabled
// R8: mark bits shift through 8-bit window
// R9: mark valid only after valid preceding tail
// R10: mark and timing always read; code skips mark decode and the tape timing track while mark writing (wtm_on)
// R11: search flags block mark, number bits 6-17
// R12: host unloads block number within 53 ms
// R13: write auto reverse check sum, flag per word
// R14: write flag two word slots ahead
// R15: data flags about one word time apart
// R16: prefinal mark raises block-end in write
// R17: host check sum is complemented ring sum
// R18: writers off after check sum
// R19: next block rewrites reverse sum, flags again
// R20: read first flag after reverse check sum
// R21: error when no valid mark per six shifts
// R22: host allows recovery time after mode change
// R23: mark equals its complement obverse
// R24: buffer shifts opposite for reverse motion
// R25: end mark stops tape, raises error
// R26: flags stay until host transfer or clear
`default_nettype none
package tape_ctl_pkg;
   localparam int WORD_W         = 18;
   localparam int TRACKS         = 3;
   localparam int LINES_PER_WORD = WORD_W / TRACKS;
   localparam int WIN_W          = 8;
   localparam int MARK_W         = 6;
   localparam int CLK_PERIOD_NS  = 40;
   localparam int LINE_TIME_NS   = 33333;
   localparam int LINE_HALF_CYC  = (LINE_TIME_NS / CLK_PERIOD_NS) / 2;

   // register map
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STAT = 2'h1;
   localparam logic [1:0] ADDR_BUF  = 2'h2;
   localparam int CTRL_MODE_LSB = 0;
   localparam int MODE_W        = 3;
   localparam int CTRL_GO_BIT   = 3;
   localparam int CTRL_REV_BIT  = 4;
   localparam int CTRL_BRK_BIT  = 5;
   localparam int STAT_DATA_BIT = 0;
   localparam int STAT_END_BIT  = 1;
   localparam int STAT_ERR_BIT  = 2;
   localparam int STAT_PERM_BIT = 3;
   localparam int STAT_SYNC_BIT = 4;

   // mark codes, forward reading
   localparam logic [5:0] MK_BLOCK = 6'h16;
   localparam logic [5:0] MK_RCHK  = 6'h08;
   localparam logic [5:0] MK_DATA  = 6'h38;
   localparam logic [5:0] MK_PRE   = 6'h33;
   localparam logic [5:0] MK_FINAL = 6'h0D;
   localparam logic [5:0] MK_END   = 6'h12;
   localparam logic [WORD_W-1:0] RCHK_VALUE = 18'h3FFFF;

   typedef enum logic [MODE_W-1:0] {
      MODE_MOVE   = 3'h0,
      MODE_SEARCH = 3'h1,
      MODE_READ   = 3'h2,
      MODE_WRITE  = 3'h3,
      MODE_WTM    = 3'h4
   } mode_t;

   typedef enum logic [4:0] {
      PH_IDLE = 5'h01,
      PH_RCHK = 5'h02,
      PH_DATA = 5'h04,
      PH_CSUM = 5'h08,
      PH_OFF  = 5'h10
   } phase_t;

   typedef struct packed {
      logic [1:0]        addr;
      logic [WORD_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } host_req_t;

   typedef struct packed {
      logic              tim;
      logic              mark;
      logic [TRACKS-1:0] data;
   } tape_in_t;

   typedef struct packed {
      logic              run;
      logic              rev;
      logic [TRACKS-1:0] data;
      logic              data_en;
      logic              mark;
      logic              tim;
      logic              tm_en;
   } tape_out_t;
endpackage : tape_ctl_pkg
`default_nettype wire

/* File: test/tape_ctl_checker.sv */
`default_nettype none
module tape_ctl_checker
   import tape_ctl_pkg::*;
(
   input wire logic              i_mclk,
   input wire logic              i_sys_rst,
   input wire host_req_t         i_host,
   input wire logic [WORD_W-1:0] o_rd_data,
   input wire logic              i_permit_sw,
   input wire tape_out_t         o_tape,
   input wire logic              o_warn_lamp,
   input wire logic              o_break_req
);
   logic [5:0] ctl_q;
   wire        ctl_wr = i_host.wr && i_host.addr == ADDR_CTRL;
   // shadow of the control register, end marks only clear go
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst)
         ctl_q <= 6'h00;
      else if (ctl_wr)
         ctl_q <= i_host.wdata[5:0];
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////
   property p_tm_guard;
      o_tape.tm_en |-> $past(ctl_q[2:0]) == MODE_WTM;
   endproperty
   a_tm_guard: assert property (p_tm_guard) else $error("tm writers outside mode");
   property p_tm_off;
      !i_permit_sw [*5] |-> !o_tape.tm_en;
   endproperty
   a_tm_off: assert property (p_tm_off) else $error("tm writers without permit");
   property p_mark_copy;
      o_tape.tm_en |-> o_tape.mark == o_tape.data[0];
   endproperty
   a_mark_copy: assert property (p_mark_copy) else $error("mark not channel one");
   property p_lamp;
      $rose(i_permit_sw) |-> ##[2:4] o_warn_lamp;
   endproperty
   a_lamp: assert property (p_lamp) else $error("warn lamp late");
   property p_brk;
      o_break_req |-> $past(ctl_q[5]);
   endproperty
   a_brk: assert property (p_brk) else $error("break while disabled");
   property p_run;
      ctl_wr && i_host.wdata[3] |-> ##[1:2] o_tape.run;
   endproperty
   a_run: assert property (p_run) else $error("tape not started");
   property p_data_en;
      o_tape.data_en |-> $past(ctl_q[2:0]) inside {MODE_WRITE, MODE_WTM};
   endproperty
   a_data_en: assert property (p_data_en) else $error("data writers outside write");
   property p_rd_idle;
      !$past(i_host.rd) |-> o_rd_data == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_unmapped;
      i_host.rd && i_host.addr == 2'h3 |=> o_rd_data == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctl_rb;
      i_host.rd && i_host.addr == ADDR_CTRL |=>
         (o_rd_data[5:0] & 6'h37) == ($past(ctl_q) & 6'h37);
   endproperty
   a_ctl_rb: assert property (p_ctl_rb) else $error("control readback wrong");
endmodule : tape_ctl_checker
bind tape_mark_track_flag_control tape_ctl_checker chk_inst (
   .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_host(i_host), .o_rd_data(o_rd_data),
   .i_permit_sw(i_permit_sw), .o_tape(o_tape), .o_warn_lamp(o_warn_lamp),
   .o_break_req(o_break_req));
`default_nettype wire

/* File: test/tape_transport_model.sv */
`default_nettype none
module tape_transport_model
   import tape_ctl_pkg::*;
(
   input  wire logic     i_run,
   input  wire logic     i_end,
   output var  tape_in_t o_tape
);
   timeunit 1ns;
   timeprecision 1ns;
   // marks in tape order keep every tail valid for the next mark;
   // a spare final slot gives the writers a gap before the next block
   logic [5:0]        seq [7] = '{MK_BLOCK, MK_RCHK, MK_DATA, MK_DATA, MK_PRE, MK_FINAL,
                                  MK_FINAL};
   int                line = 0;
   int                slot = 0;
   logic [5:0]        code;
   logic [WORD_W-1:0] word;
   assign code = i_end ? MK_END : seq[slot];
   assign word = {12'hA50 + 12'(slot), 6'h2A};
   initial o_tape = '0;
   ////////////////////////////////////////////////////////////////////
   // six lines, one mark bit each
   always begin
      #160;
      if (i_run) begin
         if (o_tape.tim) begin
            o_tape.mark = code[5 - line];
            o_tape.data = word[WORD_W - 1 - 3 * line -: 3];
         end
         o_tape.tim = ~o_tape.tim;
         if (o_tape.tim) begin
            line = (line + 1) % 6;
            if (line == 0)
               slot = (slot + 1) % 7;
         end
      end else begin
         // stopped tape gives no stable read level
         o_tape.mark = ~o_tape.mark;
         o_tape.data = ~o_tape.data;
      end
   end
endmodule : tape_transport_model
`default_nettype wire

/* File: test/tb_top.sv */
`default_nettype none
module tb_top
   import tape_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              i_mclk      = 1'b0;
   logic              i_sys_rst   = 1'b1;
   logic              i_permit_sw = 1'b0;
   logic              tape_end    = 1'b0;
   host_req_t         host        = '0;
   tape_in_t          tape_in;
   tape_out_t         tape_out;
   logic [WORD_W-1:0] rd_data;
   logic [WORD_W-1:0] v;
   logic              warn;
   logic              brk;
   int                failures = 0;
   int                checks   = 0;
   always #20 i_mclk = ~i_mclk;
   tape_mark_track_flag_control #(.LINE_HALF(4)) DUT (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_host(host), .o_rd_data(rd_data),
      .i_tape(tape_in), .i_permit_sw(i_permit_sw), .o_tape(tape_out),
      .o_warn_lamp(warn), .o_break_req(brk));
   tape_transport_model transport (.i_run(tape_out.run), .i_end(tape_end), .o_tape(tape_in));
   ////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [WORD_W-1:0] d);
      @(posedge i_mclk);
      host <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_mclk);
      host.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, output logic [WORD_W-1:0] d);
      @(posedge i_mclk);
      host <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge i_mclk);
      host.rd <= 1'b0;
      #1 d = rd_data;
   endtask : rd
   task automatic wait_stat(input int b);
      for (int n = 0; n < 400; n++) begin
         rd(ADDR_STAT, v);
         if (v[b] === 1'b1)
            return;
      end
      failures++;
      $display("Error stat bit %0d expected 1 seen 0", b);
      wrap_up();
   endtask : wait_stat
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      rd(ADDR_CTRL, v);
      chk("ctrl reset", 18'h0, v);
      rd(ADDR_STAT, v);
      chk("stat reset", 18'h0, v);
      rd(2'h3, v);
      chk("unmapped", 18'h0, v);
      wr(ADDR_CTRL, 18'h35);
      rd(ADDR_CTRL, v);
      chk("ctrl readback", 18'h35, v);
      $display("test registers done");
      i_permit_sw <= 1'b1;
      wr(ADDR_CTRL, 18'h0C);
      repeat (200) @(posedge i_mclk);
      chk("warn lamp", 18'h1, 18'(warn));
      chk("tm writers", 18'h1, 18'(tape_out.tm_en));
      rd(ADDR_STAT, v);
      chk("stat permit", 18'h1, 18'(v[STAT_PERM_BIT]));
      i_permit_sw <= 1'b0;
      repeat (8) @(posedge i_mclk);
      chk("tm writers off", 18'h0, 18'(tape_out.tm_en));
      chk("lamp off", 18'h0, 18'(warn));
      $display("test timing mark write done");
      wr(ADDR_CTRL, 18'h08);
      wr(ADDR_STAT, 18'h7);
      repeat (600) @(posedge i_mclk);
      rd(ADDR_STAT, v);
      chk("move flags", 18'h0, v & 18'h3);
      $display("test move done");
      wr(ADDR_CTRL, 18'h09);
      wait_stat(STAT_DATA_BIT);
      rd(ADDR_BUF, v);
      chk("block number", 18'h29400, v);
      wr(ADDR_CTRL, 18'h0A);
      rd(ADDR_STAT, v);
      chk("flag cleared", 18'h0, 18'(v[STAT_DATA_BIT]));
      $display("test search done");
      for (int p = 1; p < 4; p++) begin
         wait_stat(STAT_DATA_BIT);
         rd(ADDR_BUF, v);
         chk("read word", {12'hA50 + 12'(p), 6'h2A}, v);
      end
      wait_stat(STAT_END_BIT);
      rd(ADDR_BUF, v);
      chk("final word", 18'h2956A, v);
      wr(ADDR_CTRL, 18'h2A);
      repeat (300) @(posedge i_mclk);
      chk("break", 18'h1, 18'(brk));
      rd(ADDR_STAT, v);
      chk("lost word", 18'h1, 18'(v[STAT_ERR_BIT]));
      $display("test read done");
      wr(ADDR_CTRL, 18'h0B);
      wr(ADDR_STAT, 18'h7);
      v = '0;
      // host keeps every request served
      for (int n = 0; n < 400 && v[STAT_END_BIT] !== 1'b1; n++) begin
         rd(ADDR_STAT, v);
         if (v[STAT_DATA_BIT] === 1'b1)
            wr(ADDR_BUF, 18'h12345);
      end
      chk("block end", 18'h1, 18'(v[STAT_END_BIT]));
      chk("writers on", 18'h1, 18'(tape_out.data_en));
      // four words of 12345 plus 3FFFF, ring sum complemented
      wr(ADDR_BUF, 18'h372EA);
      for (int n = 0; n < 200 && tape_out.data_en === 1'b1; n++)
         @(posedge i_mclk);
      chk("writers off", 18'h0, 18'(tape_out.data_en));
      for (int n = 0; n < 200 && tape_out.data_en !== 1'b1; n++)
         @(posedge i_mclk);
      chk("writers resume", 18'h1, 18'(tape_out.data_en));
      $display("test write done");
      wr(ADDR_CTRL, 18'h08);
      wr(ADDR_STAT, 18'h7);
      tape_end <= 1'b1;
      for (int n = 0; n < 400 && tape_out.run === 1'b1; n++)
         @(posedge i_mclk);
      chk("run stop", 18'h0, 18'(tape_out.run));
      rd(ADDR_STAT, v);
      chk("end error", 18'h1, 18'(v[STAT_ERR_BIT]));
      $display("test end mark done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
